// file: src/bcc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcc_map.svh"
// Operation
// - per-mode bit 7 turns the channel on in that power mode.
// - per-mode bit 6 picks forced PWM (1) or auto pulse-skip (0).
// - bits 5-0 hold the voltage code; channel 2 resets from the pin strap.
// - channel 3 active and low-power codes reset to the 1.25 V code.
// - sequencing bits 7-6 pick the soft-start ramp rate.
// - sequencing bits 5-4 pick the start-up step of the channel.
// - participation bit 0 skips start and ignores soft-start and power-good flags.
// - delay bits 2-0 wait from previous step before soft start.
// - channel 2 fault bit 7 masks interrupt when 0; channel 3 fault bit 7 masks it when 1, inverted sense.
// - hiccup on gives endless soft-start retries, other channels keep running.
// - hiccup off shuts all channels (override channels only while the short lasts), restarts sequence after 100 ms.
// - discharge bit turns on output discharge while channel is off.
// - phase bit shifts switching 180 degrees from the oscillator.
// - configuration bits 3-2 pick the voltage scaling rate.
// - override control 0 ignores override value, mode settings rule.
// - override control 1 forces channel on or off by override value.
// - under override, forced PWM still follows the per-mode bit.
// - channel 2 has low-power, hibernate, high-performance registers at 0x21-0x23.
// - reset loads defaults; all fields read and write.
// - channel 2 active register at 0x20, code from pin strap.
module bcc_top
    import bcc_pkg::*;
#(
    parameter int RESTART_CYC = `BCC_RESTART_CYC,
    parameter int DLY_UNIT    = 4
)
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic [5:0] i_ch2_vset_pin,
    input  wire logic [1:0] i_power_mode,
    input  wire logic       i_startup,
    input  wire logic [1:0] i_fault,
    input  wire logic [1:0] i_short,
    input  wire logic [1:0] i_ss_done,
    input  wire logic [1:0] i_pgood,
    output logic      [1:0] o_enable,
    output logic      [1:0] o_forced_pwm,
    output logic     [11:0] o_output_voltage_code,
    output logic      [3:0] o_soft_start_rate,
    output logic      [3:0] o_voltage_scaling_rate,
    output logic      [1:0] o_phase_shift,
    output logic      [1:0] o_output_discharge_enable,
    output logic            o_interrupt_out_n
);
    if (RESTART_CYC < 1 || DLY_UNIT < 1 || DLY_UNIT > 585)
    begin : g_bad_param
        $error("bad timing parameter");
    end

    localparam int NREG = 12;

    logic [7:0]   reg_r [NREG];
    logic [NREG-1:0] hit;
    logic [1:0]   flt_s1_r, flt_s2_r, sh_s1_r, sh_s2_r;
    logic [1:0]   ssd_s1_r, ssd_s2_r, pok_s1_r, pok_s2_r, mode_s1_r, mode_s2_r;
    logic         st_s1_r, st_s2_r, st_d_r;
    logic [11:0]  vpin_s1_r, vpin_s2_r;
    logic [1:0]   strap_cnt_r;
    logic [1:0]   step_r;
    logic         seq_active_r;
    logic         wait_restart_r;
    logic [31:0]  restart_cnt_r;
    logic         shutdown_r;
    logic [1:0]   step_ok;
    logic         fatal;

    bcc_chan_if chif [2] ();

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        reg_index = {a[4], a[2:0]} - (a[4] ? 4'h2 : 4'h0);
    endfunction

    function automatic logic reg_valid(input logic [7:0] a);
        reg_valid = (a[7:4] == 4'h2 || a[7:4] == 4'h3) && a[3:0] <= 4'h5;
    endfunction

    // index: ch2 0..5, ch3 6..11  (addr 0x3n -> 8+n-2 = 6+n)
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_hit
            assign hit[gi] = i_wr && reg_valid(i_addr) && reg_index(i_addr) == 4'(gi);
        end
    endgenerate

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            {flt_s1_r, flt_s2_r, sh_s1_r, sh_s2_r} <= 8'h00;
            {ssd_s1_r, ssd_s2_r, pok_s1_r, pok_s2_r} <= 8'h00;
            {mode_s1_r, mode_s2_r} <= 4'h0;
            {st_s1_r, st_s2_r, st_d_r} <= 3'h0;
            vpin_s1_r <= 12'h000;
            vpin_s2_r <= 12'h000;
        end
        else if (i_ce)
        begin
            flt_s1_r  <= i_fault;
            flt_s2_r  <= flt_s1_r;
            sh_s1_r   <= i_short;
            sh_s2_r   <= sh_s1_r;
            ssd_s1_r  <= i_ss_done;
            ssd_s2_r  <= ssd_s1_r;
            pok_s1_r  <= i_pgood;
            pok_s2_r  <= pok_s1_r;
            mode_s1_r <= i_power_mode;
            mode_s2_r <= mode_s1_r;
            st_s1_r   <= i_startup;
            st_s2_r   <= st_s1_r;
            st_d_r    <= st_s2_r;
            vpin_s1_r <= {6'h00, i_ch2_vset_pin};
            vpin_s2_r <= vpin_s1_r;
        end
    end

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            reg_r[0]  <= {`BCC_RST_CH2_ACT, 6'h00};
            reg_r[1]  <= {`BCC_RST_CH2_LPM, 6'h00};
            reg_r[2]  <= {`BCC_RST_CH2_HIB, 6'h00};
            reg_r[3]  <= {`BCC_RST_CH2_HPM, 6'h00};
            reg_r[4]  <= `BCC_RST_CH2_SEQ;
            reg_r[5]  <= `BCC_RST_CH2_CFG;
            reg_r[6]  <= `BCC_RST_CH3_ACT;
            reg_r[7]  <= `BCC_RST_CH3_LPM;
            reg_r[8]  <= `BCC_RST_CH3_HIB;
            reg_r[9]  <= `BCC_RST_CH3_HPM;
            reg_r[10] <= `BCC_RST_CH3_SEQ;
            reg_r[11] <= `BCC_RST_CH3_CFG;
            strap_cnt_r <= 2'h0;
        end
        else if (i_ce)
        begin
            // strap is caught once, when the two-flop chain holds the pin value
            if (strap_cnt_r != 2'h3)
                strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == 2'h2)
            begin
                for (int k = 0; k < 4; k++)
                    reg_r[k][`BCC_VSET_MSB:0] <= vpin_s2_r[5:0];
            end
            for (int k = 0; k < NREG; k++)
                if (hit[k])
                    reg_r[k] <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_ce && i_rd)
        begin
            if (reg_valid(i_addr))
                o_rdata <= reg_r[reg_index(i_addr)];
            else if (i_addr == `BCC_OFS_STATUS)
                o_rdata <= {2'h0, wait_restart_r, seq_active_r, step_r, o_enable};
            else
                o_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // sequencer and fatal short restart
    // ------------------------------------------------------------
    assign fatal = chif[0].fatal_short | chif[1].fatal_short;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            step_r         <= 2'h0;
            seq_active_r   <= 1'b0;
            wait_restart_r <= 1'b0;
            restart_cnt_r  <= 32'h0;
            shutdown_r     <= 1'b0;
        end
        else if (i_ce)
        begin
            shutdown_r <= 1'b0;
            if (fatal)
            begin
                shutdown_r     <= 1'b1;
                seq_active_r   <= 1'b0;
                wait_restart_r <= 1'b1;
                restart_cnt_r  <= 32'(RESTART_CYC - 1);
            end
            else if (wait_restart_r)
            begin
                if (restart_cnt_r == 32'h0)
                begin
                    wait_restart_r <= 1'b0;
                    seq_active_r   <= 1'b1;
                    step_r         <= 2'h0;
                end
                else
                    restart_cnt_r <= restart_cnt_r - 32'h1;
            end
            else if (st_s2_r && !st_d_r)
            begin
                seq_active_r <= 1'b1;
                step_r       <= 2'h0;
            end
            else if (seq_active_r && (&step_ok))
            begin
                if (step_r == 2'h3)
                    seq_active_r <= 1'b0;
                else
                    step_r <= step_r + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    logic [7:0] act_mode [2];

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ch
            localparam int B = gi * 6;
            logic mine;
            assign mine = chif[gi].seq_reg[`BCC_STEP_MSB:`BCC_STEP_LSB] == step_r;
            assign act_mode[gi] = reg_r[B + 32'(mode_s2_r)];
            assign chif[gi].mode_reg     = act_mode[gi];
            assign chif[gi].seq_reg      = reg_r[B + 4];
            assign chif[gi].cfg_reg      = reg_r[B + 5];
            assign chif[gi].seq_go       = seq_active_r && mine;
            assign chif[gi].shutdown_all = shutdown_r;
            assign chif[gi].short_evt    = sh_s2_r[gi];
            assign chif[gi].ss_done      = ssd_s2_r[gi];
            assign chif[gi].pgood        = pok_s2_r[gi];
            assign step_ok[gi]           = !mine || chif[gi].seq_done;

            bcc_chan_ctrl #(.DLY_UNIT(DLY_UNIT)) u_chan
            (
                .i_core_clk (i_core_clk),
                .i_rst_n    (i_rst_n),
                .i_ce       (i_ce),
                .ch         (chif[gi])
            );

            assign o_enable[gi]     = chif[gi].enable;
        end
    endgenerate

    // ------------------------------------------------------------
    // registered data outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_forced_pwm              <= 2'h0;
            o_output_voltage_code     <= 12'h000;
            o_soft_start_rate         <= 4'h0;
            o_voltage_scaling_rate    <= 4'h0;
            o_phase_shift             <= 2'h0;
            o_output_discharge_enable <= 2'h0;
        end
        else if (i_ce)
        begin
            for (int k = 0; k < 2; k++)
            begin
                o_forced_pwm[k] <= act_mode[k][`BCC_BIT_FORCED_PWM];
                o_output_voltage_code[k*6 +: 6] <= act_mode[k][`BCC_VSET_MSB:0];
                o_soft_start_rate[k*2 +: 2] <=
                    reg_r[k*6+4][`BCC_SSR_MSB:`BCC_SSR_LSB];
                o_voltage_scaling_rate[k*2 +: 2] <=
                    reg_r[k*6+5][`BCC_DVS_MSB:`BCC_DVS_LSB];
                o_phase_shift[k] <= reg_r[k*6+5][`BCC_BIT_PHASE];
                // discharge only while the channel is off
                o_output_discharge_enable[k] <=
                    reg_r[k*6+5][`BCC_BIT_OUTPUT_DISCHARGE_ENABLE] && !o_enable[k];
            end
        end
    end

    // ------------------------------------------------------------
    // fault interrupt: ch2 unmasked when bit is 1, ch3 when bit is 0
    // ------------------------------------------------------------
    assign o_interrupt_out_n =
        !((flt_s2_r[0] && reg_r[5][`BCC_BIT_FMASK]) ||
          (flt_s2_r[1] && !reg_r[11][`BCC_BIT_FMASK]));

    property p_fatal_shutdown;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && fatal) |=> shutdown_r ##1 (o_enable == 2'h0 || reg_r[5][0] || reg_r[11][0]);
    endproperty
    a_fatal_shutdown: assert property (p_fatal_shutdown) else $error("no shutdown on short");

    property p_override;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (reg_r[5][`BCC_BIT_OVERRIDE_CONTROL] && !shutdown_r) |-> o_enable[0] == reg_r[5][`BCC_BIT_REN];
    endproperty
    a_override: assert property (p_override) else $error("override not honoured");

    property p_write_lands;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && i_wr && i_addr == `BCC_OFS_CH2_CFG) |=> reg_r[5] == $past(i_wdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");

    property p_irq_masked;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!reg_r[5][`BCC_BIT_FMASK] && !flt_s2_r[1]) |-> o_interrupt_out_n;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked fault raised irq");

    property p_pwm_follows;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_ce |=> o_forced_pwm[1] == $past(act_mode[1][`BCC_BIT_FORCED_PWM]);
    endproperty
    a_pwm_follows: assert property (p_pwm_follows) else $error("pwm mode wrong");
endmodule
`default_nettype wire

// file: src/bcc_map.svh
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define BCC_OFS_CH2_ACT    8'h20
`define BCC_OFS_CH2_LPM    8'h21
`define BCC_OFS_CH2_HIB    8'h22
`define BCC_OFS_CH2_HPM    8'h23
`define BCC_OFS_CH2_SEQ    8'h24
`define BCC_OFS_CH2_CFG    8'h25
`define BCC_OFS_CH3_ACT    8'h30
`define BCC_OFS_CH3_LPM    8'h31
`define BCC_OFS_CH3_HIB    8'h32
`define BCC_OFS_CH3_HPM    8'h33
`define BCC_OFS_CH3_SEQ    8'h34
`define BCC_OFS_CH3_CFG    8'h35
`define BCC_OFS_STATUS     8'h3f

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BCC_BIT_EN         7
`define BCC_BIT_FORCED_PWM       6
`define BCC_VSET_MSB       5
`define BCC_SSR_MSB        7
`define BCC_SSR_LSB        6
`define BCC_STEP_MSB       5
`define BCC_STEP_LSB       4
`define BCC_BIT_STEP_PARTICIPATION_ENABLE      3
`define BCC_DLY_MSB        2
`define BCC_BIT_FMASK      7
`define BCC_BIT_HICCUP     6
`define BCC_BIT_OUTPUT_DISCHARGE_ENABLE      5
`define BCC_BIT_PHASE      4
`define BCC_DVS_MSB        3
`define BCC_DVS_LSB        2
`define BCC_BIT_REN        1
`define BCC_BIT_OVERRIDE_CONTROL       0

// ------------------------------------------------------------
// reset values (ch2 voltage code bits come from the pin strap)
// ------------------------------------------------------------
`define BCC_RST_CH2_ACT    2'h3
`define BCC_RST_CH2_LPM    2'h2
`define BCC_RST_CH2_HIB    2'h2
`define BCC_RST_CH2_HPM    2'h3
`define BCC_RST_CH2_SEQ    8'h1d
`define BCC_RST_CH2_CFG    8'ha0
`define BCC_RST_CH3_ACT    8'he7
`define BCC_RST_CH3_LPM    8'ha7
`define BCC_RST_CH3_HIB    8'h27
`define BCC_RST_CH3_HPM    8'he7
`define BCC_RST_CH3_SEQ    8'h2c
`define BCC_RST_CH3_CFG    8'hb0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define BCC_CLK_HZ         25000000
`define BCC_RESTART_MS     100
`define BCC_RESTART_CYC    ((`BCC_CLK_HZ / 1000) * `BCC_RESTART_MS)

`endif

// file: src/bcc_pkg.sv
package bcc_pkg;
    typedef enum logic [1:0]
    {
        BCC_MODE_ACT = 2'h0,
        BCC_MODE_LPM = 2'h1,
        BCC_MODE_HIB = 2'h2,
        BCC_MODE_HPM = 2'h3
    } bcc_mode_type;

    typedef enum logic [1:0]
    {
        BCC_CH_OFF   = 2'h0,
        BCC_CH_WAIT  = 2'h1,
        BCC_CH_RAMP  = 2'h2,
        BCC_CH_ON    = 2'h3
    } bcc_ch_state_type;
endpackage

// file: src/bcc_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
// settings and state travelling between the bank and one channel controller
interface bcc_chan_if;
    logic [7:0] mode_reg;
    logic [7:0] seq_reg;
    logic [7:0] cfg_reg;
    logic       seq_go;
    logic       shutdown_all;
    logic       short_evt;
    logic       ss_done;
    logic       pgood;
    logic       seq_done;
    logic       fatal_short;
    logic       enable;
    logic       ramping;

    modport bank
    (
        output mode_reg, seq_reg, cfg_reg, seq_go, shutdown_all, short_evt, ss_done, pgood,
        input  seq_done, fatal_short, enable, ramping
    );
    modport chan
    (
        input  mode_reg, seq_reg, cfg_reg, seq_go, shutdown_all, short_evt, ss_done, pgood,
        output seq_done, fatal_short, enable, ramping
    );
endinterface
`default_nettype wire

// file: src/bcc_chan_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcc_map.svh"
module bcc_chan_ctrl
    import bcc_pkg::*;
#(
    parameter int DLY_UNIT = 4
)
(
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    bcc_chan_if.chan  ch
);
    // the delay counter is 12 bits wide: code 7 times the unit must fit
    if (DLY_UNIT < 1 || DLY_UNIT > 585)
    begin : g_bad_dly
        $error("DLY_UNIT out of range");
    end

    bcc_ch_state_type state_r;
    logic [11:0]      dly_r;
    logic             seq_en;
    logic             want_on;

    // ------------------------------------------------------------
    // start-up sequencing and hiccup retries
    // ------------------------------------------------------------
    assign seq_en  = ch.seq_reg[`BCC_BIT_STEP_PARTICIPATION_ENABLE];
    assign want_on = ch.mode_reg[`BCC_BIT_EN];

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= BCC_CH_OFF;
            dly_r   <= 12'h000;
        end
        else if (i_ce)
        begin
            if (ch.shutdown_all)
                state_r <= BCC_CH_OFF;
            else if (ch.short_evt && ch.cfg_reg[`BCC_BIT_HICCUP])
            begin
                state_r <= BCC_CH_RAMP;
                dly_r   <= 12'h000;
            end
            else
                unique case (state_r)
                    BCC_CH_OFF:
                        if (ch.seq_go && seq_en)
                        begin
                            state_r <= BCC_CH_WAIT;
                            dly_r   <= 12'(ch.seq_reg[`BCC_DLY_MSB:0]) * 12'(DLY_UNIT);
                        end
                    BCC_CH_WAIT:
                        if (dly_r == 12'h000)
                            state_r <= BCC_CH_RAMP;
                        else
                            dly_r <= dly_r - 12'h001;
                    BCC_CH_RAMP:
                        if (ch.ss_done)
                            state_r <= BCC_CH_ON;
                    BCC_CH_ON:
                        state_r <= BCC_CH_ON;
                endcase
        end
    end

    // flags count only for channels that take part in the sequence
    assign ch.seq_done    = !seq_en || (state_r == BCC_CH_ON && ch.pgood);
    assign ch.fatal_short = ch.short_evt && !ch.cfg_reg[`BCC_BIT_HICCUP];
    assign ch.ramping     = (state_r == BCC_CH_RAMP);

    // override wins over the mode enable when selected
    always_comb
    begin
        if (ch.cfg_reg[`BCC_BIT_OVERRIDE_CONTROL])
            ch.enable = ch.cfg_reg[`BCC_BIT_REN] && !ch.shutdown_all;
        else
            ch.enable = want_on && (state_r != BCC_CH_OFF) && (state_r != BCC_CH_WAIT);
    end

    property p_wait_to_ramp;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && state_r == BCC_CH_WAIT && dly_r == 12'h000 && !ch.shutdown_all && !ch.short_evt)
        |=> state_r == BCC_CH_RAMP;
    endproperty
    a_wait_to_ramp: assert property (p_wait_to_ramp) else $error("delay end did not ramp");

    property p_noseq_stays_off;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_r == BCC_CH_OFF && !seq_en && !ch.short_evt) |=> state_r == BCC_CH_OFF;
    endproperty
    a_noseq_stays_off: assert property (p_noseq_stays_off) else $error("non-sequenced start");
endmodule
`default_nettype wire

// file: tb/bcc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bcc_top_tb_top;
    import bcc_pkg::*;
    logic        core_clk;
    logic        rst_n;
    logic        ce;
    logic [1:0]  soft_start_done_flag;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [1:0]  power_mode;
    logic        startup;
    logic [1:0]  fault;
    logic [1:0]  short_in;
    logic [1:0]  enable;
    logic [1:0]  forced_pwm;
    logic [11:0] vcode;
    logic [3:0]  ssr;
    logic [3:0]  vsr;
    logic [1:0]  phase;
    logic [1:0]  output_discharge_enable;
    logic        int_n;
    int          fail_count;
    int          n_compared;

    bcc_top #(.RESTART_CYC(50), .DLY_UNIT(4)) dut
    (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_ch2_vset_pin(6'h2a), .i_power_mode(power_mode), .i_startup(startup),
        .i_fault(fault), .i_short(short_in), .i_ss_done(soft_start_done_flag), .i_pgood(2'b11),
        .o_enable(enable), .o_forced_pwm(forced_pwm), .o_output_voltage_code(vcode),
        .o_soft_start_rate(ssr), .o_voltage_scaling_rate(vsr), .o_phase_shift(phase),
        .o_output_discharge_enable(output_discharge_enable), .o_interrupt_out_n(int_n)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        chk({4'h0, rdata}, {4'h0, exp});
    endtask

    task automatic settle();
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_en(input logic [1:0] exp, input int lim);
        int n;
        n = 0;
        while (enable !== exp && n < lim)
        begin
            @(posedge core_clk);
            n++;
        end
        #1;
        chk({10'h0, enable}, {10'h0, exp});
        if (enable !== exp)
            end_sim();
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        reg_rd_chk(8'h20, 8'hea);
        reg_rd_chk(8'h21, 8'haa);
        reg_rd_chk(8'h22, 8'haa);
        reg_rd_chk(8'h23, 8'hea);
        reg_rd_chk(8'h24, 8'h1d);
        reg_rd_chk(8'h25, 8'ha0);
        reg_rd_chk(8'h30, 8'he7);
        reg_rd_chk(8'h31, 8'ha7);
        $display("test reset values done");
    endtask

    task automatic test_sequence_and_short();
        @(posedge core_clk);
        startup <= 1'b1;
        repeat (4) @(posedge core_clk);
        startup <= 1'b0;
        wait_en(2'b11, 2000);
        @(posedge core_clk);
        short_in <= 2'b10;
        wait_en(2'b00, 6);
        @(posedge core_clk);
        short_in <= 2'b00;
        wait_en(2'b11, 3000);
        $display("test sequence and short done");
    endtask

    task automatic test_hiccup_freeze();
        reg_wr(8'h35, 8'hf0);
        soft_start_done_flag      <= 2'b01;
        short_in <= 2'b10;
        settle();
        chk({10'h0, enable}, 12'h3);
        reg_rd_chk(8'h3f, 8'h0f);
        @(posedge core_clk);
        ce       <= 1'b0;
        short_in <= 2'b00;
        soft_start_done_flag      <= 2'b11;
        reg_wr(8'h31, 8'h00);
        ce <= 1'b1;
        settle();
        chk({10'h0, enable}, 12'h3);
        reg_rd_chk(8'h31, 8'ha7);
        $display("test hiccup and freeze done");
    endtask

    task automatic test_mode_select();
        logic [7:0] val [4];
        val = '{8'hc5, 8'h0a, 8'h4c, 8'h93};
        for (int m = 0; m < 4; m++)
            reg_wr(8'h20 + 8'(m), val[m]);
        for (int pass = 0; pass < 2; pass++)
        begin
            reg_wr(8'h25, pass == 0 ? 8'h83 : 8'h81);
            for (int m = 0; m < 4; m++)
            begin
                @(posedge core_clk);
                power_mode <= 2'(m);
                settle();
                chk({6'h0, vcode[5:0]}, {6'h0, val[m][5:0]});
                chk({11'h0, forced_pwm[0]}, {11'h0, val[m][6]});
                chk({11'h0, enable[0]}, pass == 0 ? 12'h1 : 12'h0);
            end
        end
        reg_wr(8'h20, 8'h45);
        power_mode <= 2'h0;
        reg_wr(8'h25, 8'h02);
        settle();
        chk({11'h0, enable[0]}, 12'h0);
        $display("test mode select done");
    endtask

    task automatic test_config_outputs();
        reg_wr(8'h24, 8'hc8);
        reg_wr(8'h25, 8'h99);
        reg_wr(8'h35, 8'h14);
        settle();
        chk({8'h0, ssr}, {8'h0, 4'h3});
        chk({10'h0, phase}, 12'h3);
        chk({8'h0, vsr}, {8'h0, 4'h6});
        reg_wr(8'h25, 8'ha1);
        settle();
        chk({11'h0, output_discharge_enable[0]}, 12'h1);
        reg_wr(8'h25, 8'h81);
        settle();
        chk({11'h0, output_discharge_enable[0]}, 12'h0);
        $display("test config outputs done");
    endtask

    task automatic test_fault_mask();
        @(posedge core_clk);
        fault <= 2'b01;
        reg_wr(8'h25, 8'h01);
        settle();
        chk({11'h0, int_n}, 12'h1);
        reg_wr(8'h25, 8'h81);
        settle();
        chk({11'h0, int_n}, 12'h0);
        @(posedge core_clk);
        fault <= 2'b00;
        settle();
        chk({11'h0, int_n}, 12'h1);
        $display("test fault mask done");
    endtask

    task automatic test_readback();
        logic [7:0] offs [8];
        offs = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30, 8'h31};
        for (int i = 0; i < 8; i++)
            reg_wr(offs[i], offs[i] ^ 8'h5a);
        reg_wr(8'h50, 8'hff);
        for (int i = 0; i < 8; i++)
            reg_rd_chk(offs[i], offs[i] ^ 8'h5a);
        reg_rd_chk(8'h50, 8'h00);
        $display("test readback done");
    endtask

    initial
    begin
        fail_count = 0;
        n_compared = 0;
        rst_n      = 1'b0;
        ce         = 1'b1;
        soft_start_done_flag        = 2'b11;
        addr       = 8'h00;
        wdata      = 8'h00;
        wr         = 1'b0;
        rd         = 1'b0;
        power_mode = 2'h0;
        startup    = 1'b0;
        fault      = 2'b00;
        short_in   = 2'b00;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        test_reset_values();
        test_sequence_and_short();
        test_hiccup_freeze();
        test_mode_select();
        test_config_outputs();
        test_fault_mask();
        test_readback();
        end_sim();
    end
endmodule
`default_nettype wire
